// *** design/sfs_flash_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfs_flash_seq
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic warmReset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core
    output logic coreStall,
    // flash array
    output logic arrayWrite,
    output logic arrayErase,
    output logic [15:0] arrayWordAddr,
    output logic [23:0] arrayData
);
    sfs_latch_if latch();
    sfs_pkg::sfs_seq_t seqState_reg;
    sfs_pkg::sfs_key_t keyState_reg;
    logic wren_reg, err_reg, erase_reg, memSel_reg;
    logic [1:0] size_reg;
    logic [15:0] ptr_reg;
    logic [10:0] row_reg;
    logic [2:0] rowsLeft_reg;
    logic [4:0] wordIdx_reg;
    logic [7:0] waitCnt_reg;
    logic busy, busyDly_reg;
    logic [31:0] prdata_reg;
    logic arrayWrite_reg, arrayErase_reg;
    logic [15:0] arrayWordAddr_reg;
    logic [23:0] arrayData_reg;
    logic mapped, wrEn, ctrlWr, keyWr, launch, opValid;
    logic [31:0] readValue;
    sfs_latch_mem latchMem
    (
        .clock(clock),
        .reset(reset),
        .latch(latch)
    );

    // ==========================================================
    // apb decode
    assign busy = seqState_reg != sfs_pkg::SEQ_IDLE;
    assign coreStall = busy;
    assign pready = !busy && !busyDly_reg;
    assign mapped = paddr == sfs_pkg::OFS_CTRL || paddr == sfs_pkg::OFS_KEY || paddr == sfs_pkg::OFS_PTR
        || paddr == sfs_pkg::OFS_DLOW || paddr == sfs_pkg::OFS_DHIGH;
    assign pslverr = psel && penable && pready && !mapped;
    assign wrEn = psel && penable && pwrite && pready && mapped;
    assign ctrlWr = wrEn && paddr == sfs_pkg::OFS_CTRL;
    assign keyWr = wrEn && paddr == sfs_pkg::OFS_KEY;
    assign launch = ctrlWr && pwdata[sfs_pkg::CTRL_START_BIT] && keyState_reg == sfs_pkg::KEY_ARMED;
    assign opValid = pwdata[sfs_pkg::CTRL_WREN_BIT] && !pwdata[sfs_pkg::CTRL_MEM_BIT]
        && !(pwdata[sfs_pkg::CTRL_ERASE_BIT] && pwdata[1:0] == sfs_pkg::SIZE_RSVD);

    always_comb
    begin
        readValue = 32'h00000000;
        case (paddr)
            sfs_pkg::OFS_CTRL:
            begin
                readValue[sfs_pkg::CTRL_START_BIT] = busy;
                readValue[sfs_pkg::CTRL_WREN_BIT] = wren_reg;
                readValue[sfs_pkg::CTRL_ERR_BIT] = err_reg;
                readValue[sfs_pkg::CTRL_ERASE_BIT] = erase_reg;
                readValue[sfs_pkg::CTRL_MEM_BIT] = memSel_reg;
                readValue[1:0] = size_reg;
            end
            sfs_pkg::OFS_PTR: readValue[15:0] = ptr_reg;
            default: readValue = 32'h00000000;
        endcase
    end

    // read data sampled every waiting cycle, shown at the access edge
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            prdata_reg <= 32'h00000000;
            busyDly_reg <= 1'b0;
        end
        else
        begin
            busyDly_reg <= busy;
            if (psel && !pwrite)
                prdata_reg <= readValue;
        end
    end
    assign prdata = prdata_reg;
    // ==========================================================
    // flash_op_control fields, only the power-on reset clears them
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wren_reg <= 1'b0;
            erase_reg <= 1'b0;
            memSel_reg <= 1'b0;
            size_reg <= sfs_pkg::SIZE_1ROW;
            err_reg <= 1'b0;
        end
        else
        begin
            if (ctrlWr)
            begin
                wren_reg <= pwdata[sfs_pkg::CTRL_WREN_BIT];
                erase_reg <= pwdata[sfs_pkg::CTRL_ERASE_BIT];
                memSel_reg <= pwdata[sfs_pkg::CTRL_MEM_BIT];
                size_reg <= pwdata[1:0];
                err_reg <= pwdata[sfs_pkg::CTRL_ERR_BIT] && err_reg;
            end
            if (launch && !opValid)
                err_reg <= 1'b1;
        end
    end

    // ==========================================================
    // unlock key sequence
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            keyState_reg <= sfs_pkg::KEY_IDLE;
        else if (warmReset)
            keyState_reg <= sfs_pkg::KEY_IDLE;
        else if (wrEn)
        begin
            case (keyState_reg)
                sfs_pkg::KEY_IDLE:
                    keyState_reg <= (keyWr && pwdata[7:0] == sfs_pkg::KEY_FIRST) ? sfs_pkg::KEY_GOT_FIRST
                        : sfs_pkg::KEY_IDLE;
                sfs_pkg::KEY_GOT_FIRST:
                    keyState_reg <= (keyWr && pwdata[7:0] == sfs_pkg::KEY_SECOND) ? sfs_pkg::KEY_ARMED
                        : sfs_pkg::KEY_IDLE;
                default: keyState_reg <= sfs_pkg::KEY_IDLE;
            endcase
        end
    end

    // ==========================================================
    // table pointer and latch stores
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            ptr_reg <= 16'h0000;
        else if (wrEn && paddr == sfs_pkg::OFS_PTR)
            ptr_reg <= pwdata[15:0];
        else if (wrEn && paddr == sfs_pkg::OFS_DHIGH)
            ptr_reg <= ptr_reg + 16'h0001;
    end

    assign latch.wrLow = wrEn && paddr == sfs_pkg::OFS_DLOW;
    assign latch.wrHigh = wrEn && paddr == sfs_pkg::OFS_DHIGH;
    assign latch.wrIdx = ptr_reg[4:0];
    assign latch.wrData = {pwdata[7:0], pwdata[15:0]};
    assign latch.rdEn = seqState_reg == sfs_pkg::SEQ_READ;
    assign latch.rdIdx = wordIdx_reg;

    // ==========================================================
    // operation sequencer
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            seqState_reg <= sfs_pkg::SEQ_IDLE;
            row_reg <= 11'h000;
            rowsLeft_reg <= 3'h0;
            wordIdx_reg <= 5'h00;
            waitCnt_reg <= 8'h00;
        end
        else
        begin
            case (seqState_reg)
                sfs_pkg::SEQ_IDLE:
                    if (launch && opValid)
                    begin
                        if (pwdata[sfs_pkg::CTRL_ERASE_BIT])
                        begin
                            row_reg <= sfs_pkg::alignRow(ptr_reg[15:5], pwdata[1:0]);
                            wordIdx_reg <= 5'h00;
                            rowsLeft_reg <= sfs_pkg::rowsOf(pwdata[1:0]);
                            seqState_reg <= sfs_pkg::SEQ_ERASE;
                        end
                        else
                        begin
                            row_reg <= ptr_reg[15:5];
                            wordIdx_reg <= 5'h00;
                            seqState_reg <= sfs_pkg::SEQ_READ;
                        end
                    end
                sfs_pkg::SEQ_ERASE:
                begin
                    waitCnt_reg <= sfs_pkg::ERASE_WAIT_LOAD;
                    seqState_reg <= sfs_pkg::SEQ_ERASE_WAIT;
                end
                sfs_pkg::SEQ_ERASE_WAIT:
                    if (waitCnt_reg != 8'h00)
                        waitCnt_reg <= waitCnt_reg - 8'h01;
                    else if (rowsLeft_reg == 3'h1)
                        seqState_reg <= sfs_pkg::SEQ_IDLE;
                    else
                    begin
                        row_reg <= row_reg + 11'h001;
                        rowsLeft_reg <= rowsLeft_reg - 3'h1;
                        seqState_reg <= sfs_pkg::SEQ_ERASE;
                    end
                sfs_pkg::SEQ_READ: seqState_reg <= sfs_pkg::SEQ_WRITE;
                sfs_pkg::SEQ_WRITE:
                    if (wordIdx_reg == sfs_pkg::LAST_IDX)
                    begin
                        waitCnt_reg <= sfs_pkg::PROG_WAIT_LOAD;
                        seqState_reg <= sfs_pkg::SEQ_PROG_WAIT;
                    end
                    else
                    begin
                        wordIdx_reg <= wordIdx_reg + 5'h01;
                        seqState_reg <= sfs_pkg::SEQ_READ;
                    end
                sfs_pkg::SEQ_PROG_WAIT:
                    if (waitCnt_reg != 8'h00)
                        waitCnt_reg <= waitCnt_reg - 8'h01;
                    else
                        seqState_reg <= sfs_pkg::SEQ_IDLE;
                default: seqState_reg <= sfs_pkg::SEQ_IDLE;
            endcase
        end
    end

    // ==========================================================
    // array drive, registered
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            arrayWrite_reg <= 1'b0;
            arrayErase_reg <= 1'b0;
            arrayWordAddr_reg <= 16'h0000;
            arrayData_reg <= 24'h000000;
        end
        else
        begin
            arrayWrite_reg <= seqState_reg == sfs_pkg::SEQ_WRITE;
            arrayErase_reg <= seqState_reg == sfs_pkg::SEQ_ERASE;
            arrayWordAddr_reg <= {row_reg, wordIdx_reg};
            arrayData_reg <= latch.rdData;
        end
    end
    assign arrayWrite = arrayWrite_reg;
    assign arrayErase = arrayErase_reg;
    assign arrayWordAddr = arrayWordAddr_reg;
    assign arrayData = arrayData_reg;
    // ==========================================================
    // checks
    logic [5:0] progCount_reg;
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            progCount_reg <= 6'h00;
        else if (!busy)
            progCount_reg <= 6'h00;
        else if (arrayWrite_reg)
            progCount_reg <= progCount_reg + 6'h01;
    end

    AST_START_NEEDS_KEY:
        assert property (@(posedge clock) disable iff (reset)
            $rose(busy) |-> $past(keyState_reg) == sfs_pkg::KEY_ARMED && $past(ctrlWr))
        else $error("operation started without unlock");
    AST_STALL_WHILE_BUSY:
        assert property (@(posedge clock) disable iff (reset)
            busy |-> coreStall && !pready)
        else $error("bus completed during operation");
    AST_START_BIT_READS_BUSY:
        assert property (@(posedge clock) disable iff (reset)
            psel && !pwrite && paddr == sfs_pkg::OFS_CTRL && !busy && !busyDly_reg
            |=> prdata[sfs_pkg::CTRL_START_BIT] == $past(busy))
        else $error("start bit does not follow operation");
    AST_KEY_READS_ZERO:
        assert property (@(posedge clock) disable iff (reset)
            psel && penable && !pwrite && pready && paddr == sfs_pkg::OFS_KEY && $past(psel) |-> prdata == 32'h0)
        else $error("key register returned data");
    AST_ROW_32_WORDS:
        assert property (@(posedge clock) disable iff (reset)
            $fell(busy) && !$past(erase_reg) |-> $past(progCount_reg) == 6'h20)
        else $error("program did not write a full row");
    AST_ERASE_ALIGNED:
        assert property (@(posedge clock) disable iff (reset)
            $rose(busy) && erase_reg && size_reg == sfs_pkg::SIZE_4ROW |=> row_reg[1:0] == 2'b00)
        else $error("erase block not aligned");
    AST_CANCEL_ON_OTHER_WRITE:
        assert property (@(posedge clock) disable iff (reset)
            keyState_reg == sfs_pkg::KEY_ARMED && wrEn && !ctrlWr |=> keyState_reg == sfs_pkg::KEY_IDLE)
        else $error("unlock survived a foreign write");
    AST_TWO_CYCLE_STORE:
        assert property (@(posedge clock) disable iff (reset)
            psel && !penable && pwrite && paddr == sfs_pkg::OFS_DLOW && !busy && !busyDly_reg
            |=> pready ##0 latch.wrLow)
        else $error("latch store took more than two cycles");
    AST_ARRAY_QUIET_IDLE:
        assert property (@(posedge clock) disable iff (reset)
            !busy && !$past(busy) |-> !arrayWrite && !arrayErase)
        else $error("array touched outside an operation");
    AST_CTRL_KEPT_WARM:
        assert property (@(posedge clock) disable iff (reset)
            warmReset && !ctrlWr |=> $stable(size_reg) && $stable(wren_reg) && $stable(erase_reg))
        else $error("control changed by warm reset");
endmodule
`default_nettype wire

// *** common/sfs_pkg.sv ***
package sfs_pkg;
    // ==========================================================
    // geometry
    localparam int unsigned ROW_WORDS = 32;
    localparam int unsigned ROW_BYTES = 96;
    localparam int unsigned WORD_BITS = 24;
    localparam int unsigned IDX_BITS = 5;
    localparam int unsigned PTR_BITS = 16;
    localparam int unsigned ROW_BITS = 11;
    localparam logic [4:0] LAST_IDX = 5'h1F;
    localparam logic [23:0] LATCH_RESET = 24'hFFFFFF;

    // ==========================================================
    // register map
    localparam int unsigned PADDR_BITS = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_KEY = 8'h04;
    localparam logic [7:0] OFS_PTR = 8'h08;
    localparam logic [7:0] OFS_DLOW = 8'h0C;
    localparam logic [7:0] OFS_DHIGH = 8'h10;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // ==========================================================
    // flash_op_control fields
    localparam int unsigned CTRL_START_BIT = 15;
    localparam int unsigned CTRL_WREN_BIT = 14;
    localparam int unsigned CTRL_ERR_BIT = 13;
    localparam int unsigned CTRL_ERASE_BIT = 6;
    localparam int unsigned CTRL_MEM_BIT = 5;
    localparam int unsigned CTRL_SIZE_LSB = 0;
    localparam logic [1:0] SIZE_1ROW = 2'h0;
    localparam logic [1:0] SIZE_2ROW = 2'h1;
    localparam logic [1:0] SIZE_4ROW = 2'h2;
    localparam logic [1:0] SIZE_RSVD = 2'h3;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PROG_TIME_NS = 1000;
    localparam int unsigned ERASE_TIME_NS = 2000;
    localparam int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] PROG_WAIT_LOAD = 8'(PROG_CYCLES - 1);
    localparam logic [7:0] ERASE_WAIT_LOAD = 8'(ERASE_CYCLES - 1);

    typedef enum logic [2:0] {SEQ_IDLE, SEQ_ERASE, SEQ_ERASE_WAIT, SEQ_READ, SEQ_WRITE, SEQ_PROG_WAIT} sfs_seq_t;
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} sfs_key_t;

    function automatic logic [2:0] rowsOf(input logic [1:0] size);
        case (size)
            SIZE_1ROW: rowsOf = 3'h1;
            SIZE_2ROW: rowsOf = 3'h2;
            default: rowsOf = 3'h4;
        endcase
    endfunction

    function automatic logic [10:0] alignRow(input logic [10:0] row, input logic [1:0] size);
        case (size)
            SIZE_1ROW: alignRow = row;
            SIZE_2ROW: alignRow = {row[10:1], 1'b0};
            default: alignRow = {row[10:2], 2'b00};
        endcase
    endfunction
endpackage

// *** common/sfs_latch_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sfs_latch_if;
    logic wrLow;
    logic wrHigh;
    logic [4:0] wrIdx;
    logic [23:0] wrData;
    logic rdEn;
    logic [4:0] rdIdx;
    logic [23:0] rdData;
    modport seq(output wrLow, wrHigh, wrIdx, wrData, rdEn, rdIdx, input rdData);
    modport mem(input wrLow, wrHigh, wrIdx, wrData, rdEn, rdIdx, output rdData);
endinterface
`default_nettype wire

// *** design/sfs_latch_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfs_latch_mem
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // latch port
    sfs_latch_if.mem latch
);
    logic [23:0] store[sfs_pkg::ROW_WORDS];
    logic [23:0] rdData_reg;

    // ==========================================================
    // holding latches, low word and high byte written separately
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < sfs_pkg::ROW_WORDS; i++)
            begin
                store[i] <= sfs_pkg::LATCH_RESET;
            end
        end
        else
        begin
            if (latch.wrLow)
            begin
                store[latch.wrIdx][15:0] <= latch.wrData[15:0];
            end
            if (latch.wrHigh)
            begin
                store[latch.wrIdx][23:16] <= latch.wrData[23:16];
            end
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rdData_reg <= 24'h000000;
        end
        else if (latch.rdEn)
        begin
            rdData_reg <= store[latch.rdIdx];
        end
    end

    assign latch.rdData = rdData_reg;
endmodule
`default_nettype wire

// *** testbench/sfs_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfs_flash_model
(
    // clock
    input wire logic clock,
    // flash array
    input wire logic arrayWrite,
    input wire logic arrayErase,
    input wire logic [15:0] arrayWordAddr,
    input wire logic [23:0] arrayData,
    // lookup
    input wire logic [15:0] peekAddr,
    output logic [23:0] peekData
);
    logic [23:0] mem [0:65535];
    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 24'hFFFFFF;
    end
    always @(posedge clock)
    begin
        // programming only clears bits, so a second pass without erase merges
        if (arrayWrite)
            mem[arrayWordAddr] <= mem[arrayWordAddr] & arrayData;
        if (arrayErase)
            for (int k = 0; k < 32; k++)
                mem[arrayWordAddr + 16'(k)] <= 24'hFFFFFF;
    end
    assign peekData = mem[peekAddr];
endmodule
`default_nettype wire

// *** testbench/sfs_flash_seq_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfs_flash_seq_tb;
    logic clock, reset, warmReset, psel, penable, pwrite, pready, pslverr;
    logic coreStall, arrayWrite, arrayErase;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] arrayWordAddr, peekAddr;
    logic [23:0] arrayData, peekData;
    logic [23:0] lat [0:31];
    logic [10:0] curRow, base;
    logic [32:0] rdQ [$];
    logic [40:0] arQ [$];
    logic [32:0] expR;
    logic [40:0] expA;
    int numErrors = 0, totalChecks = 0, seed = 20, cycles = 0, lastCycles = 0;

    sfs_flash_seq sfs_flash_seq_i (.clock, .reset, .warmReset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .coreStall, .arrayWrite, .arrayErase,
        .arrayWordAddr, .arrayData);
    sfs_flash_model sfs_flash_model_i (.clock, .arrayWrite, .arrayErase, .arrayWordAddr,
        .arrayData, .peekAddr, .peekData);

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ==========================================================
    // tasks
    task automatic closeOut();
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        n = 1;
        while (pready !== 1'b1)
        begin
            @(posedge clock);
            n++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        lastCycles = n + 1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        rdQ.push_back({err, exp});
        apb(1'b0, a, 32'h00000000);
    endtask

    // unlock and start; the stall is looked at in the cycle after the start
    task automatic go(input logic [31:0] ctrl, input logic stall);
        wr(sfs_pkg::OFS_KEY, 32'(sfs_pkg::KEY_FIRST));
        wr(sfs_pkg::OFS_KEY, 32'(sfs_pkg::KEY_SECOND));
        wr(sfs_pkg::OFS_CTRL, ctrl);
        @(negedge clock);
        chk("coreStall", 32'(stall), 32'(coreStall));
    endtask

    task automatic load(input logic [4:0] idx, input logic [23:0] d);
        wr(sfs_pkg::OFS_PTR, {16'h0000, curRow, idx});
        wr(sfs_pkg::OFS_DLOW, {16'h0000, d[15:0]});
        wr(sfs_pkg::OFS_DHIGH, {24'h000000, d[23:16]});
        chk("latchCycles", 32'h00000002, 32'(lastCycles));
        lat[idx] = d;
    endtask

    task automatic prog();
        for (int i = 0; i < 32; i++)
            arQ.push_back({1'b1, curRow, 5'(i), lat[i]});
        go(32'h0000C000, 1'b1);
        rd(sfs_pkg::OFS_CTRL, 32'h00004000, 1'b0);
        for (int i = 0; i < 32; i++)
        begin
            peekAddr = {curRow, 5'(i)};
            #1;
            chk("flashWord", 32'(lat[i]), 32'(peekData));
        end
    endtask

    // ==========================================================
    // watcher: each result takes the oldest note
    always @(posedge clock)
    begin
        if (psel && penable && !pwrite && pready === 1'b1)
        begin
            expR = rdQ.size() > 0 ? rdQ.pop_front() : '1;
            chk("prdata", expR[31:0], prdata);
            chk("pslverr", 32'(expR[32]), 32'(pslverr));
        end
        if (arrayWrite === 1'b1 || arrayErase === 1'b1)
        begin
            expA = arQ.size() > 0 ? arQ.pop_front() : '1;
            chk("arrayWrite", 32'(expA[40]), 32'(arrayWrite));
            chk("arrayWordAddr", 32'(expA[39:24]), 32'(arrayWordAddr));
            if (expA[40])
                chk("arrayData", 32'(expA[23:0]), 32'(arrayData));
        end
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            numErrors++;
            closeOut();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        reset = 1'b1;
        warmReset = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        peekAddr = 16'h0000;
        curRow = 11'h000;
        for (int i = 0; i < 32; i++)
            lat[i] = 24'hFFFFFF;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rd(sfs_pkg::OFS_CTRL, 32'h00000000, 1'b0);
        rd(sfs_pkg::OFS_KEY, 32'h00000000, 1'b0);
        rd(8'h20, 32'h00000000, 1'b1);
        // erase 1, 2 and 4 rows from an unaligned pointer
        for (int s = 0; s < 3; s++)
        begin
            curRow = 11'($random(seed));
            base = curRow & ~11'((1 << s) - 1);
            wr(sfs_pkg::OFS_PTR, {16'h0000, curRow, 5'($random(seed))});
            for (int k = 0; k < (1 << s); k++)
                arQ.push_back({1'b0, base + 11'(k), 5'h00, 24'h000000});
            go(32'h0000C040 | s, 1'b1);
            rd(sfs_pkg::OFS_CTRL, 32'h00004040 | s, 1'b0);
        end
        // full row in scattered order, one latch rewritten
        curRow = base;
        for (int i = 0; i < 32; i++)
            load(5'(i * 7), 24'($random(seed)));
        load(5'h03, 24'($random(seed)));
        prog();
        // two latches reloaded, the rest keep their values
        curRow = base + 11'h001;
        load(5'h1F, 24'($random(seed)));
        load(5'h00, 24'($random(seed)));
        prog();
        // start refused without unlock, or with a write in between
        wr(sfs_pkg::OFS_CTRL, 32'h0000C000);
        rd(sfs_pkg::OFS_CTRL, 32'h00004000, 1'b0);
        for (int j = 0; j < 2; j++)
        begin
            wr(sfs_pkg::OFS_KEY, 32'(sfs_pkg::KEY_FIRST));
            if (j == 0)
                wr(sfs_pkg::OFS_PTR, 32'h00000000);
            wr(sfs_pkg::OFS_KEY, 32'(sfs_pkg::KEY_SECOND));
            if (j == 1)
                wr(sfs_pkg::OFS_PTR, 32'h00000000);
            wr(sfs_pkg::OFS_CTRL, 32'h0000C000);
            rd(sfs_pkg::OFS_CTRL, 32'h00004000, 1'b0);
        end
        // reserved size and other memory flag an error
        for (int j = 0; j < 2; j++)
        begin
            go(j == 0 ? 32'h0000C043 : 32'h0000C060, 1'b0);
            rd(sfs_pkg::OFS_CTRL, j == 0 ? 32'h00006043 : 32'h00006060, 1'b0);
            wr(sfs_pkg::OFS_CTRL, 32'h00004000);
        end
        rd(sfs_pkg::OFS_CTRL, 32'h00004000, 1'b0);
        // warm reset keeps the fields and drops the unlock
        wr(sfs_pkg::OFS_CTRL, 32'h00004041);
        @(posedge clock);
        warmReset <= 1'b1;
        @(posedge clock);
        warmReset <= 1'b0;
        rd(sfs_pkg::OFS_CTRL, 32'h00004041, 1'b0);
        wr(sfs_pkg::OFS_KEY, 32'(sfs_pkg::KEY_FIRST));
        wr(sfs_pkg::OFS_KEY, 32'(sfs_pkg::KEY_SECOND));
        @(posedge clock);
        warmReset <= 1'b1;
        @(posedge clock);
        warmReset <= 1'b0;
        wr(sfs_pkg::OFS_CTRL, 32'h0000C041);
        rd(sfs_pkg::OFS_CTRL, 32'h00004041, 1'b0);
        // power-on reset clears the control fields
        @(posedge clock);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rd(sfs_pkg::OFS_CTRL, 32'h00000000, 1'b0);
        closeOut();
    end
endmodule
`default_nettype wire
